// File: inc/edhcc_defines.svh
`ifndef EDHCC_DEFINES_SVH
`define EDHCC_DEFINES_SVH

// Register offsets on the control port.
`define EDHCC_REG_FF_OFS      8'h01
`define EDHCC_REG_AP_OFS      8'h02
`define EDHCC_REG_ANC_OFS     8'h03

// Status and control bit positions in the first register.
`define EDHCC_CRC_ERR_BIT     7
`define EDHCC_FORCE_BIT       6
`define EDHCC_GEN_EN_BIT      5
// Control and status positions in the second register.
`define EDHCC_CRC_REPL_BIT    7
`define EDHCC_LUMA_ERR_BIT    6
`define EDHCC_CHROMA_ERR_BIT  5

// Reset values of the writable controls.
`define EDHCC_GEN_EN_RST      1'h1
`define EDHCC_FORCE_RST       1'h0
`define EDHCC_CRC_REPL_RST    1'h0

// Checkword polynomials: 16-bit field checkword, 18-bit line CRC.
`define EDHCC_SD_POLY         16'h1021
`define EDHCC_HD_POLY         18'h00031
`define EDHCC_SD_CRC_INIT     16'h0000
`define EDHCC_HD_CRC_INIT     18'h00000

`endif

// File: inc/edhcc_pkg.sv
package edhcc_pkg;

   // One set of error flags, most significant first: UES IDA IDH EDA EDH.
   typedef struct packed {
      logic ues;
      logic ida;
      logic idh;
      logic eda;
      logic edh;
   } edhcc_flags_t;

   // One received video word (or word pair for HD) with framing marks.
   typedef struct packed {
      logic       valid;
      logic       hd;
      logic [9:0] luma;
      logic [9:0] chroma;
      logic       inActive;
      logic       inField;
      logic       inLineCrc;
      logic [1:0] crcWord;
      logic       fieldEnd;
   } edhcc_vid_t;

   // Checkwords and flags parsed out of a received error-detection packet.
   typedef struct packed {
      logic         valid;
      logic         apCrcValid;
      logic         ffCrcValid;
      logic [15:0]  apCrc;
      logic [15:0]  ffCrc;
      edhcc_flags_t apFlags;
      edhcc_flags_t ffFlags;
      edhcc_flags_t ancFlags;
   } edhcc_rxedh_t;

   // Regenerated packet contents handed to the output inserter.
   typedef struct packed {
      logic         insert;
      logic [15:0]  apCrc;
      logic [15:0]  ffCrc;
      edhcc_flags_t apFlags;
      edhcc_flags_t ffFlags;
      edhcc_flags_t ancFlags;
   } edhcc_edhout_t;

   typedef struct packed {
      logic          genEnable;
      logic          forceInsert;
      logic          crcReplace;
      logic [15:0]   crcAp;
      logic [15:0]   crcFf;
      logic [17:0]   crcY;
      logic [17:0]   crcC;
      logic [8:0]    rxYLow;
      logic [8:0]    rxCLow;
      logic          rxSeen;
      logic          rxApErr;
      logic          rxFfErr;
      logic          ancErrField;
      edhcc_flags_t  rxApFlags;
      edhcc_flags_t  rxFfFlags;
      edhcc_flags_t  rxAncFlags;
      edhcc_flags_t  ffFlags;
      edhcc_flags_t  apFlags;
      edhcc_flags_t  ancFlags;
      logic          crcError;
      logic          lumaErr;
      logic          chromaErr;
      logic [7:0]    rdData;
      edhcc_vid_t    vidOut;
      edhcc_edhout_t edhOut;
   } edhcc_state_t;

endpackage

// File: verilog/edh_crc_check_flags.sv
`timescale 1ns/10ps
`default_nettype none
`include "edhcc_defines.svh"

// How it works
// - Full-field flags live in register 01h.
// - Active-picture flags live in register 02h.
// - Ancillary flags live in register 03h.
// - Flags refresh automatically while enabled and receiving.
// - Generator enable runs SD packet generator; resets one.
// - Force bit inserts fresh packets at every SD field end while the generator is enabled; resets zero.
// - Combined bit flags SD checksum or HD CRC errors.
// - HD luma and chroma CRC errors reported separately.
// - CRC replace substitutes computed line CRCs; resets zero.
// - SD summary bits are EDH OR EDA.
// - Register 01h bit layout: error, force, enable, flags.
// - Register 02h layout: replace, luma, chroma, flags.
// - Register 03h layout: three summaries, ancillary flags.
module edh_crc_check_flags (
   // Clock, reset and clock enable.
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    ce,
   // Control port.
   input  wire logic [7:0]              regAddr,
   input  wire logic                    regWrite,
   input  wire logic                    regRead,
   input  wire logic [7:0]              regWrData,
   output logic [7:0]                   regRdData,
   // Received video and parsed packet contents.
   input  wire edhcc_pkg::edhcc_vid_t   vidIn,
   input  wire edhcc_pkg::edhcc_rxedh_t rxEdh,
   input  wire logic                    ancChecksumErr,
   // Parallel output side.
   output edhcc_pkg::edhcc_vid_t        vidOut,
   output edhcc_pkg::edhcc_edhout_t     edhOut,
   // Summary flags.
   output logic                         full_field_summary_error,
   output logic                         active_picture_summary_error,
   output logic                         ancillary_summary_error
);
   import edhcc_pkg::*;

   edhcc_state_t st;
   edhcc_state_t next_st;

   // Words are fed least significant bit first, as on the serial link.
   function automatic logic [15:0] sdCrcStep(input logic [15:0] crc, input logic [9:0] w);
      logic [15:0] c;
      logic        fb;
      c = crc;
      for (int i = 0; i < 10; i++) begin
         fb = c[15] ^ w[i];
         c = {c[14:0], 1'b0};
         if (fb) begin
            c = c ^ `EDHCC_SD_POLY;
         end
      end
      return c;
   endfunction

   function automatic logic [17:0] hdCrcStep(input logic [17:0] crc, input logic [9:0] w);
      logic [17:0] c;
      logic        fb;
      c = crc;
      for (int i = 0; i < 10; i++) begin
         fb = c[17] ^ w[i];
         c = {c[16:0], 1'b0};
         if (fb) begin
            c = c ^ `EDHCC_HD_POLY;
         end
      end
      return c;
   endfunction

   // Received CRC words carry nine payload bits and an inverted copy of bit 8.
   function automatic logic [9:0] crcWordOut(input logic [8:0] half);
      return {~half[8], half};
   endfunction

   logic [17:0] rxYCrc;
   logic [17:0] rxCCrc;
   logic        sdFieldEnd;
   logic        running;
   logic        sdApErr;
   logic        sdFfErr;

   always_comb begin
      next_st = st;
      rxYCrc = {vidIn.luma[8:0], st.rxYLow};
      rxCCrc = {vidIn.chroma[8:0], st.rxCLow};
      running = st.genEnable && vidIn.valid;
      sdFieldEnd = running && !vidIn.hd && vidIn.fieldEnd;
      sdApErr = st.rxSeen && st.rxApErr;
      sdFfErr = st.rxSeen && st.rxFfErr;

      // Control port: writes to control bits, reads answered next cycle.
      if (regWrite) begin
         case (regAddr)
            `EDHCC_REG_FF_OFS: begin
               next_st.forceInsert = regWrData[`EDHCC_FORCE_BIT];
               next_st.genEnable = regWrData[`EDHCC_GEN_EN_BIT];
            end
            `EDHCC_REG_AP_OFS: begin
               next_st.crcReplace = regWrData[`EDHCC_CRC_REPL_BIT];
            end
            default: begin
            end
         endcase
      end
      if (regRead) begin
         case (regAddr)
            `EDHCC_REG_FF_OFS: begin
               next_st.rdData = {st.crcError, st.forceInsert, st.genEnable,
                                 st.ffFlags};
            end
            `EDHCC_REG_AP_OFS: begin
               next_st.rdData = {st.crcReplace, st.lumaErr, st.chromaErr,
                                 st.apFlags};
            end
            `EDHCC_REG_ANC_OFS: begin
               next_st.rdData = {full_field_summary_error, active_picture_summary_error,
                                 ancillary_summary_error, st.ancFlags};
            end
            default: begin
               next_st.rdData = 8'h00;
            end
         endcase
      end

      // Received packet: keep its flags and compare checkwords against the
      // running values before the field end closes them.
      if (rxEdh.valid && st.genEnable) begin
         next_st.rxSeen = 1'b1;
         next_st.rxApFlags = rxEdh.apFlags;
         next_st.rxFfFlags = rxEdh.ffFlags;
         next_st.rxAncFlags = rxEdh.ancFlags;
         next_st.rxApErr = rxEdh.apCrcValid && (rxEdh.apCrc != st.crcAp);
         next_st.rxFfErr = rxEdh.ffCrcValid && (rxEdh.ffCrc != st.crcFf);
      end
      if (running && ancChecksumErr) begin
         next_st.ancErrField = 1'b1;
      end

      // Output video is one register behind the input.
      next_st.vidOut = vidIn;

      if (running && !vidIn.hd) begin
         if (vidIn.inActive) begin
            next_st.crcAp = sdCrcStep(st.crcAp, vidIn.luma);
         end
         if (vidIn.inField) begin
            next_st.crcFf = sdCrcStep(st.crcFf, vidIn.luma);
         end
      end

      // HD line CRCs: accumulate, then compare and optionally replace.
      if (running && vidIn.hd) begin
         if (vidIn.inLineCrc) begin
            next_st.crcY = hdCrcStep(st.crcY, vidIn.luma);
            next_st.crcC = hdCrcStep(st.crcC, vidIn.chroma);
         end
         if (vidIn.crcWord[0]) begin
            // The output copy may already hold our own word, so the received
            // low halves are kept apart for the comparison on the next word.
            next_st.rxYLow = vidIn.luma[8:0];
            next_st.rxCLow = vidIn.chroma[8:0];
            if (st.crcReplace) begin
               next_st.vidOut.luma = crcWordOut(st.crcY[8:0]);
               next_st.vidOut.chroma = crcWordOut(st.crcC[8:0]);
            end
         end
         if (vidIn.crcWord[1]) begin
            next_st.lumaErr = rxYCrc != st.crcY;
            next_st.chromaErr = rxCCrc != st.crcC;
            next_st.crcError = (rxYCrc != st.crcY) || (rxCCrc != st.crcC);
            next_st.crcY = `EDHCC_HD_CRC_INIT;
            next_st.crcC = `EDHCC_HD_CRC_INIT;
            if (st.crcReplace) begin
               next_st.vidOut.luma = crcWordOut(st.crcY[17:9]);
               next_st.vidOut.chroma = crcWordOut(st.crcC[17:9]);
            end
         end
      end

      // Field end: refresh all three flag sets and issue the regenerated packet.
      next_st.edhOut.insert = 1'b0;
      if (sdFieldEnd) begin
         next_st.crcError = sdApErr || sdFfErr;
         next_st.ffFlags = '{ues: !st.rxSeen || st.rxFfFlags.ues,
                             ida: st.rxFfFlags.ida || st.rxFfFlags.idh,
                             idh: 1'b0,
                             eda: st.rxFfFlags.eda || st.rxFfFlags.edh,
                             edh: sdFfErr};
         next_st.apFlags = '{ues: !st.rxSeen || st.rxApFlags.ues,
                             ida: st.rxApFlags.ida || st.rxApFlags.idh,
                             idh: 1'b0,
                             eda: st.rxApFlags.eda || st.rxApFlags.edh,
                             edh: sdApErr};
         next_st.ancFlags = '{ues: !st.rxSeen || st.rxAncFlags.ues,
                              ida: st.rxAncFlags.ida || st.rxAncFlags.idh,
                              idh: 1'b0,
                              eda: st.rxAncFlags.eda || st.rxAncFlags.edh,
                              edh: st.ancErrField || ancChecksumErr};
         // Without force a packet is only rewritten where one arrived, so a
         // stream that never carried packets is not altered silently.
         next_st.edhOut.insert = st.forceInsert || st.rxSeen;
         next_st.edhOut.apCrc = st.crcAp;
         next_st.edhOut.ffCrc = st.crcFf;
         next_st.edhOut.apFlags = next_st.apFlags;
         next_st.edhOut.ffFlags = next_st.ffFlags;
         next_st.edhOut.ancFlags = next_st.ancFlags;
         next_st.crcAp = `EDHCC_SD_CRC_INIT;
         next_st.crcFf = `EDHCC_SD_CRC_INIT;
         next_st.rxSeen = 1'b0;
         next_st.rxApErr = 1'b0;
         next_st.rxFfErr = 1'b0;
         next_st.ancErrField = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
         st.genEnable <= `EDHCC_GEN_EN_RST;
         st.forceInsert <= `EDHCC_FORCE_RST;
         st.crcReplace <= `EDHCC_CRC_REPL_RST;
         st.crcAp <= `EDHCC_SD_CRC_INIT;
         st.crcFf <= `EDHCC_SD_CRC_INIT;
         st.crcY <= `EDHCC_HD_CRC_INIT;
         st.crcC <= `EDHCC_HD_CRC_INIT;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign regRdData = st.rdData;
   assign vidOut = st.vidOut;
   assign edhOut = st.edhOut;
   assign full_field_summary_error = st.ffFlags.edh || st.ffFlags.eda;
   assign active_picture_summary_error = st.apFlags.edh || st.apFlags.eda;
   assign ancillary_summary_error = st.ancFlags.edh || st.ancFlags.eda;

endmodule
`default_nettype wire

// File: dv/edhcc_properties.sv
`timescale 1ns/10ps
`default_nettype none
module edhcc_properties import edhcc_pkg::*; (
   // Clock, reset and register reads.
   input wire logic                     clk,
   input wire logic                     srst,
   input wire logic                     ce,
   input wire logic [7:0]               regAddr,
   input wire logic                     regRead,
   input wire logic [7:0]               regRdData,
   // Video path and summaries.
   input wire edhcc_pkg::edhcc_vid_t    vidIn,
   input wire edhcc_pkg::edhcc_vid_t    vidOut,
   input wire edhcc_pkg::edhcc_edhout_t edhOut,
   input wire logic                     full_field_summary_error,
   input wire logic                     active_picture_summary_error,
   input wire logic                     ancillary_summary_error
);
   logic [2:0] sums;
   logic [2:0] sumQ;
   logic       endQ;
   assign sums = {full_field_summary_error, active_picture_summary_error, ancillary_summary_error};
   // Registered copies keep the cause one edge back, so no sampled function sees an expression.
   always_ff @(posedge clk) begin
      sumQ <= sums;
      endQ <= vidIn.valid & ~vidIn.hd & vidIn.fieldEnd;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst || !ce);
   sequence rd(logic [7:0] a);
      regRead && regAddr == a;
   endsequence
   sequence sdEnd;
      vidIn.valid && !vidIn.hd && vidIn.fieldEnd;
   endsequence
   a_sum_readback:
      assert property (rd(8'h03) |=> regRdData[7:5] == sumQ) else $error("summary readback");
   a_unmapped_zero:
      assert property (regRead && (regAddr == 8'h00 || regAddr > 8'h03) |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   a_read_holds:
      assert property (!regRead |=> $stable(regRdData)) else $error("read data moved");
   a_video_copy:
      assert property (vidIn.crcWord == 2'h0 |=> vidOut == $past(vidIn)) else $error("video copy");
   a_crc_form:
      assert property (vidOut.valid && vidOut.crcWord != 2'h0 |-> (vidOut.luma[9] ^ vidOut.luma[8])
         && (vidOut.chroma[9] ^ vidOut.chroma[8])) else $error("line check word form");
   a_insert_pulse:
      assert property (sdEnd ##1 edhOut.insert |=> !edhOut.insert) else $error("insert too long");
   a_insert_cause:
      assert property (edhOut.insert |-> endQ) else $error("insert without field end");
   a_sum_refresh:
      assert property (sums != sumQ |-> endQ) else $error("summary moved mid field");
endmodule
bind edh_crc_check_flags edhcc_properties u_edhcc_properties (.clk(clk), .srst(srst), .ce(ce),
   .regAddr(regAddr), .regRead(regRead), .regRdData(regRdData), .vidIn(vidIn), .vidOut(vidOut),
   .edhOut(edhOut), .full_field_summary_error(full_field_summary_error),
   .active_picture_summary_error(active_picture_summary_error),
   .ancillary_summary_error(ancillary_summary_error));
`default_nettype wire

// File: dv/edhcc_source.sv
`timescale 1ns/10ps
`default_nettype none
module edhcc_source import edhcc_pkg::*; (
   // Word clock.
   input wire logic                     clk,
   // Stream towards the checker, plus the true luma check word of the last line (HD) or field (SD).
   output var edhcc_pkg::edhcc_vid_t    vidIn,
   output var edhcc_pkg::edhcc_rxedh_t  rxEdh,
   output logic                         ancChecksumErr,
   output logic [17:0]                  crcY
);
   int seed = 32'h52a49565;
   initial begin
      vidIn = '0;
      rxEdh = '0;
      ancChecksumErr = 1'b0;
      crcY = '0;
   end
   function automatic logic [17:0] upd(logic [17:0] c, logic [9:0] d, logic [17:0] p, int w);
      for (int i = 0; i < 10; i++) begin
         c = (c[w-1] ^ d[i]) ? ((c << 1) ^ p) : (c << 1);
      end
      return c & ((18'h1 << w) - 18'h1);
   endfunction
   // A corrupted check word only flips bit 0, so the low word carries the fault.
   task automatic send(input logic hd, input logic [1:0] bad, input logic noPkt,
                       input logic anc, input logic [14:0] fl);
      logic [17:0] cc;
      logic [17:0] yy;
      cc = '0;
      crcY = '0;
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         vidIn = '0;
         vidIn.valid = 1'b1;
         vidIn.hd = hd;
         vidIn.inActive = ~hd;
         vidIn.inField = ~hd;
         vidIn.inLineCrc = hd;
         vidIn.luma = 10'($random(seed));
         vidIn.chroma = 10'($random(seed));
         // The checker only counts ancillary faults on valid words.
         ancChecksumErr = anc && (i == 9);
         crcY = upd(crcY, vidIn.luma, hd ? 18'h00031 : 18'h01021, hd ? 18 : 16);
         cc = upd(cc, vidIn.chroma, 18'h00031, 18);
      end
      yy = crcY ^ {17'h0, bad[0]};
      cc = cc ^ {17'h0, bad[1]};
      if (hd) begin
         for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            vidIn.inLineCrc = 1'b0;
            vidIn.crcWord = 2'(k + 1);
            vidIn.luma = {~yy[9*k+8], yy[9*k+:9]};
            vidIn.chroma = {~cc[9*k+8], cc[9*k+:9]};
         end
      end else begin
         @(negedge clk);
         vidIn = '0;
         rxEdh = {~noPkt, 2'h3, yy[15:0], crcY[15:0] ^ {15'h0, bad[1]}, fl};
         ancChecksumErr = 1'b0;
         @(negedge clk);
         rxEdh = '0;
         ancChecksumErr = 1'b0;
         vidIn.valid = 1'b1;
         vidIn.fieldEnd = 1'b1;
      end
      @(negedge clk);
      vidIn = '0;
   endtask
endmodule
`default_nettype wire

// File: dv/edh_crc_check_flags_test.sv
`timescale 1ns/10ps
`default_nettype none
module edh_crc_check_flags_test;
   import edhcc_pkg::*;
   logic          clk, srst, ce, regWrite, regRead, sawIns, ffSum, apSum, ancSum, ancErr, anc;
   logic [7:0]    regAddr, regWrData, regRdData;
   logic [17:0]   crcY;
   logic [4:0]    eFf, eAp, eAnc;
   logic          eCrc, eY, eC, eForce, eGen, eRepl;
   logic [1:0]    bad;
   logic [14:0]   fl;
   int            mismatches, tests_run, seed;
   edhcc_vid_t    vidIn, vidOut;
   edhcc_rxedh_t  rxEdh;
   edhcc_edhout_t edhOut;
   edh_crc_check_flags u_edh_crc_check_flags (.clk(clk), .srst(srst), .ce(ce), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
      .vidIn(vidIn), .rxEdh(rxEdh), .ancChecksumErr(ancErr), .vidOut(vidOut), .edhOut(edhOut),
      .full_field_summary_error(ffSum), .active_picture_summary_error(apSum),
      .ancillary_summary_error(ancSum));
   edhcc_source u_edhcc_source (.clk(clk), .vidIn(vidIn), .rxEdh(rxEdh), .ancChecksumErr(ancErr),
      .crcY(crcY));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {regAddr, regWrData, regWrite} = {a, d, 1'b1};
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge clk);
      {regAddr, regRead} = {a, 1'b1};
      @(negedge clk);
      regRead = 1'b0;
      chk(10'(regRdData & m), 10'(e & m));
   endtask
   function automatic logic [4:0] der(logic [4:0] r, logic m);
      return {r[4], r[3] | r[2], 1'b0, r[1] | r[0], m};
   endfunction
   task automatic verify;
      logic [2:0] s;
      s = {eFf[1] | eFf[0], eAp[1] | eAp[0], eAnc[1] | eAnc[0]};
      rdChk(8'h01, {eCrc, eForce, eGen, eFf}, 8'hff);
      rdChk(8'h02, {eRepl, eY, eC, eAp}, 8'hff);
      rdChk(8'h03, {s, eAnc}, 8'hff);
      chk({7'h0, ffSum, apSum, ancSum}, {7'h0, s});
   endtask
   // Without the generator nothing may refresh, so expectations stay put.
   task automatic sdField(input logic [1:0] b, input logic a, input logic [14:0] f);
      sawIns = 1'b0;
      u_edhcc_source.send(1'b0, b, 1'b0, a, f);
      if (eGen) begin
         {eAp, eFf, eAnc, eCrc} = {der(f[14:10], b[0]), der(f[9:5], b[1]), der(f[4:0], a), |b};
      end
      chk({edhOut.apFlags, edhOut.ffFlags}, {eAp, eFf});
      if (eGen) begin
         chk(edhOut.ffCrc[9:0], crcY[9:0]);
         chk({edhOut.apCrc[15:11], edhOut.ancFlags}, {crcY[15:11], eAnc});
      end
      verify();
      chk({9'h0, sawIns}, {9'h0, eGen});
   endtask
   always @(negedge clk) begin
      if (edhOut.insert === 1'b1) sawIns = 1'b1;
      if (eRepl && vidOut.valid === 1'b1 && vidOut.crcWord[0] === 1'b1) begin
         chk(vidOut.luma, {~crcY[8], crcY[8:0]});
      end
      if (eRepl && vidOut.valid === 1'b1 && vidOut.crcWord[1] === 1'b1) begin
         chk(vidOut.luma, {~crcY[17], crcY[17:9]});
      end
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      complete_run();
   end
   initial begin
      {srst, ce, regWrite, regRead, sawIns, regAddr, regWrData} = {5'h18, 16'h0};
      {mismatches, tests_run, seed} = {32'h0, 32'h0, 32'h52a49565};
      {eFf, eAp, eAnc, eCrc, eY, eC, eForce, eGen, eRepl} = 21'h2;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      verify();
      rdChk(8'h00, 8'h00, 8'hff);
      rdChk(8'h04, 8'h00, 8'hff);
      wr(8'h03, 8'hff);
      wr(8'h01, 8'hff);
      wr(8'h02, 8'hff);
      {eForce, eRepl} = 2'h3;
      verify();
      for (int i = 0; i < 2; i++) begin
         sawIns = 1'b0;
         u_edhcc_source.send(1'b0, 2'h0, 1'b1, 1'b0, 15'h0);
         // The read first lets the insert monitor finish its own edge.
         rdChk(8'h01, 8'h10, 8'h10);
         chk({9'h0, sawIns}, {9'h0, eForce});
         wr(8'h01, 8'h20);
         eForce = 1'b0;
      end
      for (int i = 0; i < 8; i++) begin
         {bad, anc, fl} = 18'($random(seed));
         if (i < 2) {bad, anc, fl} = i ? 18'h3ffff : 18'h0;
         sdField(bad, anc, fl);
      end
      wr(8'h01, 8'h00);
      eGen = 1'b0;
      sdField(2'h3, 1'b1, 15'h7fff);
      wr(8'h01, 8'h20);
      eGen = 1'b1;
      for (int b = 0; b < 4; b++) begin
         u_edhcc_source.send(1'b1, 2'(b), 1'b0, 1'b0, 15'h0);
         {eY, eC, eCrc} = {b[0], b[1], b[0] | b[1]};
         verify();
      end
      complete_run();
   end
endmodule
`default_nettype wire
